// ### shared/scau_cfg.svh
// Constants for the signed 16-bit compare and arithmetic unit
`ifndef SCAU_CFG_SVH
`define SCAU_CFG_SVH

`define SCAU_WORD_W       16
`define SCAU_DWORD_W      32
`define SCAU_SIGN_BIT     15
`define SCAU_DSIGN_BIT    31
`define SCAU_DIGIT_W      3
`define SCAU_STEP_W       8
`define SCAU_STEPS        256
`define SCAU_DIGITS_WORD  3'h0
`define SCAU_DIGITS_ONE   3'h1
`define SCAU_DIGITS_TWO   3'h2
`define SCAU_DIGITS_THREE 3'h3
`define SCAU_MASK_ONE     16'h000f
`define SCAU_MASK_TWO     16'h00ff
`define SCAU_MASK_THREE   16'h0fff
`define SCAU_MASK_FULL    16'hffff
`define SCAU_ERR_RESET    1'h0
`define SCAU_EDGE_RESET   1'h0
`define SCAU_LATENCY      1

`endif

// ### shared/scau_pkg.sv
// Types for the signed 16-bit compare and arithmetic unit
package scau_pkg;

  typedef enum logic [2:0] {
    SCAU_OP_CMP = 3'h0,
    SCAU_OP_ADD = 3'h1,
    SCAU_OP_SUB = 3'h2,
    SCAU_OP_MUL = 3'h3,
    SCAU_OP_DIV = 3'h4
  } scau_op_type;

  typedef enum logic [2:0] {
    SCAU_CND_EQ = 3'h0,
    SCAU_CND_NE = 3'h1,
    SCAU_CND_GT = 3'h2,
    SCAU_CND_LE = 3'h3,
    SCAU_CND_LT = 3'h4,
    SCAU_CND_GE = 3'h5
  } scau_cond_type;

  typedef enum logic [1:0] {
    SCAU_FORM_LINE     = 2'h0,
    SCAU_FORM_SERIES   = 2'h1,
    SCAU_FORM_PARALLEL = 2'h2
  } scau_form_type;

  typedef struct packed {
    scau_op_type   op;
    scau_cond_type cond;
    scau_form_type form;
    logic          three_op;
    logic          pulse;
    logic [2:0]    s1_digits;
    logic [2:0]    s2_digits;
    logic [2:0]    d_digits;
    logic [15:0]   first_source;
    logic [15:0]   second_source;
    logic [31:0]   dst;
  } scau_req_type;

  typedef struct packed {
    logic        contact;
    logic        dst_we;
    logic        dst_wide;
    logic [31:0] dst_data;
  } scau_res_type;

endpackage : scau_pkg

// ### design/scau_digit_mask.sv
// Keeps the low nibble groups of a bit-device operand selected by a digit count
`timescale 1ns/1ps
`include "scau_cfg.svh"

module scau_digit_mask
  import scau_pkg::*;
(
  // Operand
  input  wire logic [2:0]  digits_in,
  input  wire logic [15:0] data_in,
  // Masked operand
  output logic      [15:0] data_out
);

  logic [15:0] mask;

  always_comb begin
    case (digits_in)
      `SCAU_DIGITS_ONE:   mask = `SCAU_MASK_ONE;
      `SCAU_DIGITS_TWO:   mask = `SCAU_MASK_TWO;
      `SCAU_DIGITS_THREE: mask = `SCAU_MASK_THREE;
      default:            mask = `SCAU_MASK_FULL;
    endcase
  end

  assign data_out = data_in & mask;

endmodule : scau_digit_mask

// ### design/scau_core.sv
// Signed 16-bit comparison, add, subtract, multiply and divide unit
// Functional notes
// - Comparisons treat both operands as signed, top bit set means negative.
// - Six conditions: equal, not equal, greater, less-equal, less, greater-equal.
// - Each condition comes as line start, series and parallel forms.
// - A comparison result acts as a normally-open contact.
// - Line and parallel forms run every scan; series only after an ON contact.
// - Addition past the largest positive value wraps to negative.
// - Subtraction below the most negative value wraps to positive.
// - Addition: destination plus source, or first plus second source.
// - Subtraction: destination minus source, or first minus second source.
// - No carry or borrow indication exists.
// - Add and subtract values span signed 16 bits, sign in bit 15.
// - Multiplication writes the signed product of both sources.
// - A bit-group product destination fills from its lowest bit.
// - Ordinary sign rules; quotient truncates to zero, remainder has dividend sign.
// - Digit counts select nibble groups from bit zero, four covering 16 bits.
// - The product is 32-bit signed with sign in bit 31.
// - Word division stores quotient low and remainder high.
// - A zero divisor sets the operation error flag.
`timescale 1ns/1ps
`include "scau_cfg.svh"

module scau_core
  import scau_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  // Step request from the scan engine
  input  wire logic                   step_valid_in,
  input  wire logic [7:0]             step_idx_in,
  input  wire scau_req_type           req_in,
  input  wire logic                   exec_cond_in,
  input  wire logic                   prior_in,
  input  wire logic                   err_clr_in,
  // Step result
  output logic                        done_out,
  output scau_res_type                res_out,
  output logic                        operation_error_flag_out
);

  logic [15:0]  s1_m;
  logic [15:0]  s2_m;
  logic [15:0]  narrow_m;
  logic [15:0]  narrow_raw;
  logic         cmp_hit;
  logic         edge_prev;
  logic         run_arith;
  logic [15:0]  sum;
  logic [15:0]  diff;
  logic [31:0]  prod;
  logic [15:0]  quot;
  logic [15:0]  rem;
  logic [15:0]  divisor;
  logic         div_zero;

  logic         done_q;
  logic         done_d;
  scau_res_type res_q;
  scau_res_type res_d;
  logic         err_q;
  logic         err_d;
  logic [`SCAU_STEPS-1:0] edge_mem_q;
  logic [`SCAU_STEPS-1:0] edge_mem_d;

  scau_digit_mask u_mask_s1 (
    .digits_in (req_in.s1_digits),
    .data_in   (req_in.first_source),
    .data_out  (s1_m)
  );

  scau_digit_mask u_mask_s2 (
    .digits_in (req_in.s2_digits),
    .data_in   (req_in.second_source),
    .data_out  (s2_m)
  );

  scau_digit_mask u_mask_dst (
    .digits_in (req_in.d_digits),
    .data_in   (narrow_raw),
    .data_out  (narrow_m)
  );

  // Signed relation between first and second source
  always_comb begin
    case (req_in.cond)
      SCAU_CND_EQ: cmp_hit = (s1_m == s2_m);
      SCAU_CND_NE: cmp_hit = (s1_m != s2_m);
      SCAU_CND_GT: cmp_hit = ($signed(s1_m) >  $signed(s2_m));
      SCAU_CND_LE: cmp_hit = ($signed(s1_m) <= $signed(s2_m));
      SCAU_CND_LT: cmp_hit = ($signed(s1_m) <  $signed(s2_m));
      SCAU_CND_GE: cmp_hit = ($signed(s1_m) >= $signed(s2_m));
      default:     cmp_hit = 1'b0;
    endcase
  end

  // Arithmetic datapath, all results wrap with no carry kept
  always_comb begin
    if (req_in.three_op) begin
      sum  = s1_m + s2_m;
      diff = s1_m - s2_m;
    end else begin
      sum  = req_in.dst[15:0] + s1_m;
      diff = req_in.dst[15:0] - s1_m;
    end
    // Sign-extend first so the low 32 bits hold the signed product
    prod     = {{16{s1_m[15]}}, s1_m} * {{16{s2_m[15]}}, s2_m};
    div_zero = (s2_m == 16'h0000);
    divisor  = div_zero ? 16'h0001 : s2_m;
    quot     = 16'($signed(s1_m) / $signed(divisor));
    rem      = 16'($signed(s1_m) % $signed(divisor));
  end

  assign edge_prev = edge_mem_q[step_idx_in];
  assign run_arith = exec_cond_in && !(req_in.pulse && edge_prev);

  always_comb begin
    case (req_in.op)
      SCAU_OP_ADD: narrow_raw = sum;
      SCAU_OP_SUB: narrow_raw = diff;
      SCAU_OP_MUL: narrow_raw = prod[15:0];
      SCAU_OP_DIV: narrow_raw = quot;
      default:     narrow_raw = 16'h0000;
    endcase
  end

  // Next result, error flag and pulse edge memory
  always_comb begin
    done_d           = step_valid_in;
    res_d            = res_q;
    res_d.dst_we     = 1'b0;
    err_d            = err_q & ~err_clr_in;
    edge_mem_d       = edge_mem_q;
    if (step_valid_in) begin
      res_d.dst_wide = 1'b0;
      if (req_in.op == SCAU_OP_CMP) begin
        case (req_in.form)
          SCAU_FORM_SERIES:   res_d.contact = prior_in && cmp_hit;
          SCAU_FORM_PARALLEL: res_d.contact = prior_in || cmp_hit;
          default:            res_d.contact = cmp_hit;
        endcase
      end else begin
        edge_mem_d[step_idx_in] = exec_cond_in;
        if (run_arith) begin
          if (req_in.op == SCAU_OP_DIV && div_zero) begin
            err_d = 1'b1;
          end else begin
            res_d.dst_we = 1'b1;
            if (req_in.d_digits != `SCAU_DIGITS_WORD) begin
              res_d.dst_data = {16'h0000, narrow_m};
            end else if (req_in.op == SCAU_OP_MUL) begin
              res_d.dst_wide = 1'b1;
              res_d.dst_data = prod;
            end else if (req_in.op == SCAU_OP_DIV) begin
              res_d.dst_wide = 1'b1;
              res_d.dst_data = {rem, quot};
            end else begin
              res_d.dst_data = {16'h0000, narrow_raw};
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      done_q     <= 1'b0;
      res_q      <= '0;
      err_q      <= `SCAU_ERR_RESET;
      edge_mem_q <= '0;
    end else begin
      done_q     <= done_d;
      res_q      <= res_d;
      err_q      <= err_d;
      edge_mem_q <= edge_mem_d;
    end
  end

  assign done_out                 = done_q;
  assign res_out                  = res_q;
  assign operation_error_flag_out = err_q;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  logic cmp_word;
  logic arith_word;
  assign cmp_word   = step_valid_in && req_in.op == SCAU_OP_CMP
                      && req_in.s1_digits == 3'h0 && req_in.s2_digits == 3'h0;
  assign arith_word = step_valid_in && req_in.op != SCAU_OP_CMP
                      && req_in.d_digits == 3'h0 && req_in.s1_digits == 3'h0
                      && req_in.s2_digits == 3'h0;

  AST_CMP_NEG_LESS: assert property (
    cmp_word && req_in.form == SCAU_FORM_LINE && req_in.cond == SCAU_CND_LT
    && req_in.first_source[15] && !req_in.second_source[15] |=> res_out.contact)
    else $error("negative first source not less than positive second");

  AST_SERIES_BLOCKED: assert property (
    step_valid_in && req_in.op == SCAU_OP_CMP && req_in.form == SCAU_FORM_SERIES
    && !prior_in |=> !res_out.contact)
    else $error("series compare conducted after OFF contact");

  AST_PARALLEL_HOLD: assert property (
    step_valid_in && req_in.op == SCAU_OP_CMP && req_in.form == SCAU_FORM_PARALLEL
    && prior_in |=> res_out.contact)
    else $error("parallel compare dropped ON prior result");

  AST_ADD_WRAP: assert property (
    arith_word && req_in.op == SCAU_OP_ADD && req_in.three_op && !req_in.pulse
    && exec_cond_in && req_in.first_source == 16'h7fff && req_in.second_source == 16'h0001
    |=> res_out.dst_we && res_out.dst_data == 32'h0000_8000)
    else $error("addition did not wrap to negative");

  AST_SUB_TWO_OP: assert property (
    arith_word && req_in.op == SCAU_OP_SUB && !req_in.three_op && !req_in.pulse
    && exec_cond_in |=> res_out.dst_data[15:0]
    == 16'($past(req_in.dst[15:0]) - $past(req_in.first_source)) && !res_out.dst_wide)
    else $error("two-operand subtraction wrong");

  AST_OFF_NO_WRITE: assert property (
    step_valid_in && req_in.op != SCAU_OP_CMP && !exec_cond_in |=> !res_out.dst_we)
    else $error("destination written with condition OFF");

  AST_PULSE_ONCE: assert property (
    step_valid_in && req_in.op != SCAU_OP_CMP && req_in.pulse && edge_prev
    |=> !res_out.dst_we)
    else $error("pulse operation repeated on held condition");

  AST_MUL_SIGN: assert property (
    arith_word && req_in.op == SCAU_OP_MUL && exec_cond_in && !req_in.pulse
    && req_in.first_source != 16'h0000 && req_in.second_source != 16'h0000
    |=> res_out.dst_wide && res_out.dst_data[31]
    == ($past(req_in.first_source[15]) ^ $past(req_in.second_source[15])))
    else $error("product sign wrong");

  AST_REM_SIGN: assert property (
    arith_word && req_in.op == SCAU_OP_DIV && exec_cond_in && !req_in.pulse
    && req_in.second_source != 16'h0000
    |=> res_out.dst_data[31:16] == 16'h0000
    || res_out.dst_data[31] == $past(req_in.first_source[15]))
    else $error("remainder sign differs from dividend");

  AST_DIV_ZERO: assert property (
    step_valid_in && req_in.op == SCAU_OP_DIV && run_arith && s2_m == 16'h0000
    |=> operation_error_flag_out && !res_out.dst_we)
    else $error("zero divisor not flagged");

  AST_DIGIT_LOW: assert property (
    step_valid_in && req_in.op != SCAU_OP_CMP && req_in.d_digits == 3'h1 && run_arith
    && !(req_in.op == SCAU_OP_DIV && s2_m == 16'h0000)
    |=> res_out.dst_we && res_out.dst_data[31:4] == 28'h0000000)
    else $error("single digit destination wider than a nibble");

  COV_SERIES_ON: cover property (
    step_valid_in && req_in.form == SCAU_FORM_SERIES && prior_in ##1 res_out.contact);
  COV_DIV_ZERO: cover property (operation_error_flag_out);
  COV_MUL_WIDE: cover property (res_out.dst_we && res_out.dst_wide);

endmodule : scau_core

// ### dv/scau_mem_model.sv
// Device memory model that supplies destination words and takes result writes
`timescale 1ns/1ps
module scau_mem_model
  import scau_pkg::*;
(
  // Scan side
  input  wire logic         clk_in,
  input  wire logic [7:0]   idx_in,
  input  wire scau_res_type res_in,
  // Destination pair
  output logic      [31:0]  dst_out
);
  logic [15:0] mem_q [256];
  logic [7:0]  widx_q;

  initial foreach (mem_q[k]) mem_q[k] = 16'h0;
  assign dst_out = {mem_q[8'(idx_in + 8'h1)], mem_q[idx_in]};

  // The write strobe belongs to the step taken one edge earlier
  always @(posedge clk_in) begin
    widx_q <= idx_in;
    if (res_in.dst_we) begin
      mem_q[widx_q] <= res_in.dst_data[15:0];
      if (res_in.dst_wide) mem_q[8'(widx_q + 8'h1)] <= res_in.dst_data[31:16];
    end
  end
endmodule : scau_mem_model

// ### dv/tb_top.sv
// Self-checking bench for the compare and arithmetic unit
`timescale 1ns/1ps
module tb_top;
  import scau_pkg::*;
  typedef struct packed {scau_res_type r; logic e;} scau_note_type;
  logic          clk = 1'h0;
  logic          rst = 1'h1;
  logic          vld = 1'h0;
  logic [7:0]    idx = 8'h0;
  logic          ex = 1'h0;
  logic          pri = 1'h0;
  logic          clr = 1'h0;
  scau_req_type  req = '0;
  scau_req_type  req_w;
  logic [31:0]   dst_w;
  logic          done;
  scau_res_type  res;
  logic          err;
  logic          ct_q = 1'h0;
  logic          er_q = 1'h0;
  logic [31:0]   dd_q = 32'h0;
  logic          pm_q [256];
  scau_note_type nq [$];
  scau_note_type n;
  int            err_count = 0;
  int            checks = 0;

  always #20 clk = ~clk;
  always_comb begin
    req_w = req;
    req_w.dst = dst_w;
  end

  scau_core u_dut (.core_clk_in(clk), .rst_in(rst), .step_valid_in(vld), .step_idx_in(idx),
    .req_in(req_w), .exec_cond_in(ex), .prior_in(pri), .err_clr_in(clr), .done_out(done),
    .res_out(res), .operation_error_flag_out(err));
  scau_mem_model u_mem (.clk_in(clk), .idx_in(idx), .res_in(res), .dst_out(dst_w));

  task automatic chk(input logic [63:0] g, x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  function automatic logic [15:0] msk(input logic [2:0] d, input logic [15:0] v);
    return d == 3'h0 ? v : v & (16'hffff >> (16 - 4 * d));
  endfunction : msk

  // Drives one step and notes the result it must give
  task automatic step(input scau_req_type rq, input logic [7:0] i, input logic e, p, c);
    logic signed [15:0] a;
    logic signed [15:0] b;
    logic signed [15:0] xo;
    logic signed [15:0] yo;
    logic [31:0]        q;
    logic               ok;
    scau_res_type       x;
    @(posedge clk);
    vld <= 1'h1;
    req <= rq;
    idx <= i;
    ex <= e;
    pri <= p;
    clr <= c;
    #1;
    rq.dst = dst_w;
    a = msk(rq.s1_digits, rq.first_source);
    b = msk(rq.s2_digits, rq.second_source);
    xo = rq.three_op ? a : rq.dst[15:0];
    yo = rq.three_op ? b : a;
    x = '{ct_q, 1'h0, 1'h0, dd_q};
    ok = e && !(rq.pulse && pm_q[i]);
    if (rq.op == SCAU_OP_CMP) begin
      case (rq.cond)
        SCAU_CND_EQ: ok = a == b;
        SCAU_CND_NE: ok = a != b;
        SCAU_CND_GT: ok = a > b;
        SCAU_CND_LE: ok = a <= b;
        SCAU_CND_LT: ok = a < b;
        default: ok = a >= b;
      endcase
      if (rq.form == SCAU_FORM_SERIES) ok = ok && p;
      if (rq.form == SCAU_FORM_PARALLEL) ok = ok || p;
      x.contact = ok;
      ct_q = ok;
    end else begin
      pm_q[i] = e;
      case (rq.op)
        SCAU_OP_ADD: q = 32'(xo + yo);
        SCAU_OP_SUB: q = 32'(xo - yo);
        SCAU_OP_MUL: q = a * b;
        default: q = {16'(a % b), 16'(a / b)};
      endcase
      x.dst_we = ok && (rq.op != SCAU_OP_DIV || b != 16'sh0);
      x.dst_wide = x.dst_we && rq.op > SCAU_OP_SUB && rq.d_digits == 3'h0;
      if (x.dst_we) x.dst_data = x.dst_wide ? q : {16'h0, msk(rq.d_digits, q[15:0])};
      dd_q = x.dst_data;
    end
    if (ok && rq.op == SCAU_OP_DIV && b == 16'sh0) er_q = 1'h1;
    else if (c) er_q = 1'h0;
    nq.push_back('{x, er_q});
  endtask : step

  task automatic ar(input scau_op_type o, input logic t, u, input logic [15:0] s1, s2,
                    input logic [7:0] i, input logic e, c);
    scau_req_type r;
    r = '0;
    r.op = o;
    r.three_op = t;
    r.pulse = u;
    r.first_source = s1;
    r.second_source = s2;
    step(r, i, e, 1'h0, c);
  endtask : ar

  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk);
      vld <= 1'h0;
      clr <= 1'h0;
    end
  endtask : idle

  // Takes the oldest note whenever a result appears
  always @(posedge clk) begin
    #1;
    if (done === 1'h1) begin
      n = nq.size() > 0 ? nq.pop_front() : 'x;
      chk({res, err}, n);
    end
  end

  initial begin
    scau_req_type r;
    void'($urandom(48513));
    foreach (pm_q[k]) pm_q[k] = 1'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk({done, res, err}, 64'h0);
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 24; k++) begin
        r = '0;
        r.cond = scau_cond_type'(k % 6);
        r.form = scau_form_type'(f);
        r.first_source = k < 6 ? 16'h8001 : 16'($urandom);
        r.second_source = k < 6 ? 16'h0568 : (k < 12 ? r.first_source : 16'($urandom));
        if (k >= 12) {r.s1_digits, r.s2_digits} = {3'($urandom_range(4)), 3'($urandom_range(4))};
        step(r, 8'h0, 1'h0, 1'($urandom), 1'h0);
      end
    end
    ar(SCAU_OP_ADD, 1'h1, 1'h0, 16'h7fff, 16'h0001, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_SUB, 1'h1, 1'h0, 16'h8000, 16'h0001, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_MUL, 1'h1, 1'h0, 16'h162e, 16'h04d2, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_MUL, 1'h1, 1'h0, 16'hfffb, 16'hfffd, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_DIV, 1'h1, 1'h0, 16'hfffb, 16'h0003, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_DIV, 1'h1, 1'h0, 16'h0005, 16'hfffd, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_DIV, 1'h1, 1'h0, 16'h8000, 16'hffff, 8'h10, 1'h1, 1'h0);
    ar(SCAU_OP_DIV, 1'h1, 1'h0, 16'h0007, 16'h0000, 8'h10, 1'h1, 1'h1);
    ar(SCAU_OP_ADD, 1'h1, 1'h0, 16'h0001, 16'h0001, 8'h10, 1'h1, 1'h1);
    for (int k = 0; k < 3; k++) begin
      ar(SCAU_OP_ADD, 1'h0, 1'h0, 16'h4001, 16'h0000, 8'h20, 1'h1, 1'h0);
      ar(SCAU_OP_SUB, 1'h0, 1'h0, 16'h0003, 16'h0000, 8'h22, 1'h1, 1'h0);
      idle(2);
    end
    for (int k = 0; k < 4; k++) begin
      ar(SCAU_OP_ADD, 1'h0, 1'h1, 16'h0005, 16'h0000, 8'h30, k != 2, 1'h0);
      ar(SCAU_OP_SUB, 1'h0, 1'h0, 16'h0001, 16'h0000, 8'h32, k[0], 1'h0);
      idle(2);
    end
    for (int k = 0; k < 300; k++) begin
      r = '0;
      r.op = scau_op_type'(3'($urandom_range(4, 1)));
      {r.three_op, r.pulse} = 2'($urandom);
      {r.first_source, r.second_source} = $urandom;
      {r.s1_digits, r.s2_digits} = {3'($urandom_range(4)), 3'($urandom_range(4))};
      r.d_digits = 3'($urandom_range(4));
      step(r, 8'($urandom_range(3)), 1'($urandom), 1'h0, $urandom_range(9) == 0);
    end
    idle(1);
    for (int k = 0; k < 10 && nq.size() > 0; k++) @(posedge clk);
    if (nq.size() != 0) err_count++;
    complete_run();
  end
endmodule : tb_top
